/* File: verif/pfc_link_model.sv */
// link-side model that accepts rx command updates from the register bank
`timescale 1ns/10ps
module pfc_link_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       dir_i,
  input  wire logic       rxcmd_send_i,
  output logic      [7:0] rxcmd_count_o,
  output logic      [7:0] dir_fall_count_o
);
  logic dir_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rxcmd_count_o    <= 8'h00;
      dir_fall_count_o <= 8'h00;
      dir_r            <= 1'b0;
    end
    else
    begin
      dir_r <= dir_i;
      // only taken while the phy owns the bus
      if (dir_i && rxcmd_send_i) rxcmd_count_o <= rxcmd_count_o + 8'h01;
      if (dir_r && !dir_i) dir_fall_count_o <= dir_fall_count_o + 8'h01;
    end
  end
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the function-control register bank
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        wake = 1'b0, pd_p = 1'b0, pd_m = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  wire  [31:0] rdat;
  wire         ack, pdn, crst, dir, rxs, tsel, nd, raw, pre, pu, hst;
  wire  [1:0]  spd, mode;
  wire  [7:0]  nrx, nfall;
  int          fail_count = 0, cmp_count = 0, n;
  always #5 clk_i = ~clk_i;
  pfc_regs i_pfc_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wake_i(wake), .plus_line_pulldown_i(pd_p),
    .minus_line_pulldown_i(pd_m), .power_down_o(pdn), .core_reset_o(crst), .dir_o(dir),
    .rxcmd_send_o(rxs), .speed_select_o(spd), .line_drive_mode_o(mode),
    .termination_select_o(tsel), .tx_non_driving_o(nd), .raw_encoding_o(raw),
    .fs_preamble_en_o(pre), .pullup_en_o(pu), .hs_term_en_o(hst));
  pfc_link_model i_pfc_link_model (.clk_i(clk_i), .rst_i(rst_i), .dir_i(dir),
    .rxcmd_send_i(rxs), .rxcmd_count_o(nrx), .dir_fall_count_o(nfall));
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task bound(input int k);
    if (k >= 40)
    begin
      fail_count++;
      $display("wrong value wait expected done seen timeout");
      wrap_up;
    end
  endtask
  // request held until ack is sampled at a rising edge
  task bus(input logic w, input logic [7:0] a, d, output logic [31:0] q);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    bound(n);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [7:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK("read data", {24'h000000, e}, q)
  endtask
  task settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    settle;
    `CHK("speed", 2'h1, spd)
    `CHK("low power", 1'b0, pdn)
    rd(8'h10, 8'h41);
    done("reset");
    wr(8'h10, 8'h96);
    rd(8'h10, 8'h16);
    settle;
    `CHK("low power", 1'b1, pdn)
    `CHK("raw", 1'b1, raw)
    `CHK("pullup", 1'b1, pu)
    `CHK("term select", 1'b1, tsel)
    done("write");
    @(posedge clk_i);
    wake <= 1'b1;
    for (n = 0; n < 40 && pdn !== 1'b0; n++) @(posedge clk_i);
    bound(n);
    wake <= 1'b0;
    rd(8'h10, 8'h56);
    done("wake");
    wr(8'h14, 8'h01);
    rd(8'h14, 8'h57);
    settle;
    `CHK("preamble", 1'b1, pre)
    wr(8'h18, 8'h12);
    rd(8'h18, 8'h45);
    @(posedge clk_i);
    pd_p <= 1'b1;
    pd_m <= 1'b1;
    settle;
    `CHK("pullup", 1'b0, pu)
    @(posedge clk_i);
    pd_p <= 1'b0;
    pd_m <= 1'b0;
    done("alias");
    for (int i = 0; i < 3; i++)
    begin
      // mode three is never written from the link side
      wr(8'h10, 8'h40 | 8'(i * 9));
      settle;
      `CHK("speed", 2'(i), spd)
      `CHK("mode", 2'(i), mode)
      `CHK("non driving", i == 1, nd)
      `CHK("raw", i == 2, raw)
      `CHK("hs term", i == 0, hst)
      `CHK("term select", 1'b0, tsel)
      `CHK("preamble", 1'b0, pre)
    end
    done("modes");
    wr(8'h2C, 8'hFF);
    rd(8'h2C, 8'h00);
    rd(8'h10, 8'h52);
    done("unmapped");
    wr(8'h14, 8'h20);
    for (n = 0; n < 40 && dir !== 1'b1; n++) @(posedge clk_i);
    bound(n);
    `CHK("core reset", 1'b1, crst)
    rd(8'h10, 8'h52);
    rd(8'h20, 8'h06);
    for (n = 0; n < 40 && crst !== 1'b0; n++) @(posedge clk_i);
    bound(n);
    repeat (6) @(posedge clk_i);
    `CHK("rx commands", 8'h01, nrx)
    `CHK("dir falls", 8'h02, nfall)
    rd(8'h10, 8'h52);
    rd(8'h20, 8'h00);
    done("core reset");
    wrap_up;
  end
endmodule

/* File: verilog/pfc_params.svh */
// constants for the function-control register bank
// What this block does
// - low-power bit cleared enters low power mode
// - hardware sets low-power bit on wake exit
// - reset bit resets core only, not registers
// - reset runs dir high, low, high, rx command
// - reset bit self-clears, always reads zero
// - line drive mode selects transmit encoding
// - termination select drives pull-up and terminations
// - speed select enables chosen transceiver speed
// - speed three prepends full-speed preamble
// - set alias writes ones set bits
// - clear alias writes ones clear bits
// - aliases share the one physical register
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH
// register indices; byte address is four times the index
`define PFC_IDX_FUNC        6'h04
`define PFC_IDX_FUNC_SET    6'h05
`define PFC_IDX_FUNC_CLR    6'h06
`define PFC_IDX_STATUS      6'h08
// field positions
`define PFC_BIT_RSVD        7
`define PFC_BIT_LOWPWR_N    6
`define PFC_BIT_XRST        5
`define PFC_POS_MODE_HI     4
`define PFC_POS_MODE_LO     3
`define PFC_BIT_TERM        2
`define PFC_POS_SPEED_HI    1
`define PFC_POS_SPEED_LO    0
// reset value and writable mask
`define PFC_FUNC_RESET      8'h41
`define PFC_FUNC_WMASK      8'h7F
// transceiver core reset length in clock cycles
`define PFC_CORE_RST_CYCLES 16
`endif

/* File: verilog/pfc_pkg.sv */
// types for the function-control register bank
package pfc_pkg;
  typedef enum logic [1:0] {
    PFC_SPEED_HS,
    PFC_SPEED_FS,
    PFC_SPEED_LS,
    PFC_SPEED_FS4LS
  } pfc_speed_type;
  typedef enum logic [1:0] {
    PFC_MODE_NORMAL,
    PFC_MODE_NONDRIVE,
    PFC_MODE_RAW,
    PFC_MODE_RSVD
  } pfc_mode_type;
  typedef enum {
    PFC_ST_IDLE,
    PFC_ST_CORE,
    PFC_ST_DIRLOW,
    PFC_ST_TURN,
    PFC_ST_RXCMD
  } pfc_state_type;
endpackage

/* File: verilog/pfc_regs.sv */
// function-control register bank with wishbone slave and reset handshake
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "pfc_params.svh"
module pfc_regs
  import pfc_pkg::*;
#(
  parameter int CORE_RST_CYCLES = `PFC_CORE_RST_CYCLES
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        wake_i,
  input  wire logic        plus_line_pulldown_i,
  input  wire logic        minus_line_pulldown_i,
  output logic             power_down_o,
  output logic             core_reset_o,
  output logic             dir_o,
  output logic             rxcmd_send_o,
  output logic [1:0]       speed_select_o,
  output logic [1:0]       line_drive_mode_o,
  output logic             termination_select_o,
  output logic             tx_non_driving_o,
  output logic             raw_encoding_o,
  output logic             fs_preamble_en_o,
  output logic             pullup_en_o,
  output logic             hs_term_en_o
);

  localparam int CW = $clog2(CORE_RST_CYCLES + 1);

  if (CORE_RST_CYCLES < 1)
  begin : g_chk
    $error("CORE_RST_CYCLES must be at least 1");
  end

  logic [7:0]    func_r;
  logic [7:0]    func_nxt;
  logic          ack_r;
  logic [31:0]   rdat_r;
  logic [7:0]    rdat_nxt;
  logic          wr_go;
  logic          rd_go;
  logic [5:0]    idx;
  pfc_state_type state_r;
  logic [CW-1:0] cnt_r;
  logic          dir_r;
  logic          core_rst_r;
  logic          rxcmd_r;
  logic          rst_done;
  logic          wake_s1_r;
  logic          wake_s2_r;
  logic          wake_s3_r;
  logic          wake_r;
  logic          wake_rise;
  logic [7:0]    out_r;
  logic          pu_r;
  logic          hst_r;

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  assign idx   = wb_adr_i[7:2];
  // a write lands at the edge where the master samples ack, not before
  assign wr_go = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0];
  assign rd_go = wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i;

  // one wait state: ack rises the edge after the request, drops the next
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
  end

  always_comb
  begin
    rdat_nxt = 8'h00;
    if (idx == `PFC_IDX_FUNC || idx == `PFC_IDX_FUNC_SET || idx == `PFC_IDX_FUNC_CLR)
    begin
      rdat_nxt = func_r;
      rdat_nxt[`PFC_BIT_XRST] = 1'b0;
      rdat_nxt[`PFC_BIT_RSVD] = 1'b0;
    end
    else if (idx == `PFC_IDX_STATUS)
      rdat_nxt = {4'h0, rxcmd_r, dir_r, core_rst_r, ~func_r[`PFC_BIT_LOWPWR_N]};
    else
      rdat_nxt = 8'h00;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_r <= 32'h0000_0000;
    else if (rd_go)
      rdat_r <= {24'h00_0000, rdat_nxt};
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ------------------------------------------------------------
  // function-control storage
  // ------------------------------------------------------------
  // the aliases have no storage: all three addresses act on func_r
  always_comb
  begin
    func_nxt = func_r;
    if (wr_go)
    begin
      if (idx == `PFC_IDX_FUNC)
        func_nxt = wb_dat_i[7:0] & `PFC_FUNC_WMASK;
      else if (idx == `PFC_IDX_FUNC_SET)
        func_nxt = func_r | (wb_dat_i[7:0] & `PFC_FUNC_WMASK);
      else if (idx == `PFC_IDX_FUNC_CLR)
        func_nxt = func_r & ~(wb_dat_i[7:0] & `PFC_FUNC_WMASK);
      else
        func_nxt = func_r;
      // a direct write must not cut a core reset short
      if (state_r != PFC_ST_IDLE)
        func_nxt[`PFC_BIT_XRST] = func_r[`PFC_BIT_XRST];
    end
    if (rst_done)
      func_nxt[`PFC_BIT_XRST] = 1'b0;
    // hardware wake wins over a software clear in the same cycle only if low power was already entered
    if (wake_rise && !func_r[`PFC_BIT_LOWPWR_N])
      func_nxt[`PFC_BIT_LOWPWR_N] = 1'b1;
    func_nxt[`PFC_BIT_RSVD] = 1'b0;
  end

  // only the bus reset reloads this; the core reset only clears its reset bit, at its end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      func_r <= `PFC_FUNC_RESET;
    else
      func_r <= func_nxt;
  end

  // ------------------------------------------------------------
  // wake pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      wake_s3_r <= 1'b0;
      wake_r    <= 1'b0;
    end
    else
    begin
      wake_s1_r <= wake_i;
      wake_s2_r <= wake_s1_r;
      wake_s3_r <= wake_s2_r;
      if (wake_s2_r == wake_s3_r)
        wake_r <= wake_s3_r;
    end
  end

  assign wake_rise = (wake_s2_r == wake_s3_r) && wake_s3_r && !wake_r;

  // ------------------------------------------------------------
  // transceiver reset and dir handshake
  // ------------------------------------------------------------
  assign rst_done = (state_r == PFC_ST_CORE) && (cnt_r == CW'(CORE_RST_CYCLES - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r    <= PFC_ST_IDLE;
      cnt_r      <= '0;
      dir_r      <= 1'b0;
      core_rst_r <= 1'b0;
      rxcmd_r    <= 1'b0;
    end
    else
    begin
      case (state_r)
        PFC_ST_IDLE:
        begin
          if (func_r[`PFC_BIT_XRST])
          begin
            state_r    <= PFC_ST_CORE;
            cnt_r      <= '0;
            dir_r      <= 1'b1;
            core_rst_r <= 1'b1;
          end
        end
        PFC_ST_CORE:
        begin
          cnt_r <= cnt_r + CW'(1);
          if (rst_done)
          begin
            state_r    <= PFC_ST_DIRLOW;
            core_rst_r <= 1'b0;
            dir_r      <= 1'b0;
          end
        end
        PFC_ST_DIRLOW:
        begin
          state_r <= PFC_ST_TURN;
          dir_r   <= 1'b1;
        end
        PFC_ST_TURN:
        begin
          state_r <= PFC_ST_RXCMD;
          rxcmd_r <= 1'b1;
        end
        PFC_ST_RXCMD:
        begin
          state_r <= PFC_ST_IDLE;
          rxcmd_r <= 1'b0;
          dir_r   <= 1'b0;
        end
        default:
        begin
          state_r <= PFC_ST_IDLE;
        end
      endcase
    end
  end

  assign dir_o        = dir_r;
  assign core_reset_o = core_rst_r;
  assign rxcmd_send_o = rxcmd_r;

  // ------------------------------------------------------------
  // transceiver controls
  // ------------------------------------------------------------
  // mode three is never programmed by the link; decoded as normal here, while line_drive_mode_o still carries three
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_r <= 8'h00;
    else
    begin
      out_r[0] <= ~func_r[`PFC_BIT_LOWPWR_N];
      out_r[1] <= func_r[`PFC_POS_MODE_HI:`PFC_POS_MODE_LO] == PFC_MODE_NONDRIVE;
      out_r[2] <= func_r[`PFC_POS_MODE_HI:`PFC_POS_MODE_LO] == PFC_MODE_RAW;
      out_r[3] <= func_r[`PFC_POS_SPEED_HI:`PFC_POS_SPEED_LO] == PFC_SPEED_FS4LS;
      out_r[5:4] <= func_r[`PFC_POS_SPEED_HI:`PFC_POS_SPEED_LO];
      out_r[7:6] <= func_r[`PFC_POS_MODE_HI:`PFC_POS_MODE_LO];
    end
  end

  // pull-up only for a full/low speed device; hs terminations only in hs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pu_r  <= 1'b0;
      hst_r <= 1'b0;
    end
    else
    begin
      pu_r  <= func_r[`PFC_BIT_TERM] && func_r[1:0] != PFC_SPEED_HS
               && func_r[4:3] != PFC_MODE_NONDRIVE
               && !(plus_line_pulldown_i && minus_line_pulldown_i);
      hst_r <= !func_r[`PFC_BIT_TERM] && func_r[1:0] == PFC_SPEED_HS
               && func_r[4:3] != PFC_MODE_NONDRIVE;
    end
  end

  assign power_down_o         = out_r[0];
  assign tx_non_driving_o     = out_r[1];
  assign raw_encoding_o       = out_r[2];
  assign fs_preamble_en_o     = out_r[3];
  assign speed_select_o       = out_r[5:4];
  assign line_drive_mode_o    = out_r[7:6];
  assign termination_select_o = func_r[`PFC_BIT_TERM];
  assign pullup_en_o          = pu_r;
  assign hs_term_en_o         = hst_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_LOWPWR_ENTER: assert property (
    $fell(func_r[`PFC_BIT_LOWPWR_N]) |=> power_down_o)
    else $error("low power not entered");
  AST_WAKE_EXIT: assert property (
    (wake_rise && power_down_o && !func_r[`PFC_BIT_LOWPWR_N]) |=> ##1 !power_down_o)
    else $error("low power not left on wake");
  AST_BUS_DURING_RST: assert property (
    (core_reset_o && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus stalled by core reset");
  AST_DIR_SEQ: assert property (
    $fell(core_reset_o) |-> (!dir_o && !func_r[`PFC_BIT_XRST]) ##1 (dir_o && !rxcmd_send_o)
      ##1 (dir_o && rxcmd_send_o) ##1 (!dir_o && !rxcmd_send_o))
    else $error("dir handshake wrong");
  AST_XRST_READ: assert property (
    (wb_ack_o && !wb_we_i) |-> !wb_dat_o[`PFC_BIT_XRST])
    else $error("reset bit read as one");
  AST_MODE_OUT: assert property (
    ##1 (tx_non_driving_o == ($past(func_r[4:3]) == PFC_MODE_NONDRIVE)))
    else $error("line drive mode output wrong");
  AST_PREAMBLE: assert property (
    (func_r[1:0] == PFC_SPEED_FS4LS) ##1 $stable(func_r[1:0]) |-> fs_preamble_en_o)
    else $error("preamble not enabled");
  AST_SET_ALIAS: assert property (
    (wr_go && idx == `PFC_IDX_FUNC_SET && !rst_done && !wake_rise)
      |=> (func_r[4:0] & $past(wb_dat_i[4:0])) == $past(wb_dat_i[4:0]))
    else $error("set alias failed");
  AST_CLR_ALIAS: assert property (
    (wr_go && idx == `PFC_IDX_FUNC_CLR && state_r == PFC_ST_IDLE)
      |=> (func_r[4:0] & $past(wb_dat_i[4:0])) == 5'h00)
    else $error("clear alias failed");
  AST_RSVD_ZERO: assert property (
    !func_r[`PFC_BIT_RSVD])
    else $error("reserved bit set");

endmodule
